// ===== rtl/twi_pkg.sv
// Shared constants for the two-wire sensor bus port and its master.
// ****************************************************************
// Function
// ****************************************************************
package twi_pkg;
    localparam logic [7:0] dev_addr_byte = 8'hb8;
    localparam int bit_rate_hz = 100000;
    localparam int link_clk_hz = 250000000;
    localparam int half_bit_cycles = (link_clk_hz + 2 * bit_rate_hz - 1) / (2 * bit_rate_hz);
    // Four engine steps make one bit, so a step is half of a half bit.
    localparam int quarter_bit_cycles = half_bit_cycles / 2;
    localparam int seq_limit_ms = 3000;
    localparam int link_period_ns = 64;
    localparam int seq_limit_cycles = (seq_limit_ms * 1000) / link_period_ns * 1000;
endpackage

// ===== rtl/twi_if.sv
// Interface joining the bus master and the sensor port over clock and data wires.
`timescale 1ns/1ps
interface twi_if;
    logic scl_out;
    logic scl_oe_n;
    logic sda_m_out;
    logic sda_m_oe_n;
    logic sda_d_out;
    logic sda_d_oe_n;
    wire scl = scl_oe_n ? 1'b1 : scl_out;
    wire sda = (sda_m_oe_n ? 1'b1 : sda_m_out) & (sda_d_oe_n ? 1'b1 : sda_d_out);
    modport master (output scl_out, output scl_oe_n, output sda_m_out, output sda_m_oe_n,
                    input scl, input sda);
    modport device (output sda_d_out, output sda_d_oe_n, input scl, input sda);
endinterface

// ===== rtl/twi_device.sv
// Sensor end: addressed target on the two-wire bus, clocked by the link clock that samples the bus lines.
`timescale 1ns/1ps
module twi_device #(
    parameter int seq_limit = twi_pkg::seq_limit_cycles
) (
    input wire logic link_clk,
    input wire logic core_clk,
    input wire logic reset,
    twi_if.device bus,
    input wire logic [7:0] tx_data,
    output logic tx_taken,
    output logic [7:0] rx_data,
    output logic rx_valid,
    output logic busy
);
    import twi_pkg::*;
    // ****************************************************************
    // Bus sampling
    // ****************************************************************
    // The bus lines are asynchronous to both clocks, so they pass two flops first.
    logic [1:0] scl_s, sda_s;
    logic scl_q, sda_q;
    logic [1:0] rst_s;
    logic lrst;
    wire scl_hi = scl_s[1];
    wire sda_hi = sda_s[1];
    wire start_seen = scl_hi && scl_q && sda_q && !sda_hi;
    wire stop_seen = scl_hi && scl_q && !sda_q && sda_hi;
    wire scl_rise = scl_hi && !scl_q;
    wire scl_fall = !scl_hi && scl_q;
    typedef enum {st_idle, st_addr, st_rx, st_tx, st_ack_out, st_ack_in, st_ignore} state_e;
    state_e state, next_state;
    logic [7:0] shift;
    logic [3:0] bit_cnt;
    logic rw;
    logic drive_low;
    logic got_nack;
    logic [31:0] seq_cnt;
    logic rx_tgl, tx_tgl;
    logic [2:0] rx_tgl_s, tx_tgl_s;
    logic busy_l;
    logic [1:0] busy_s;
    wire byte_done = scl_fall && bit_cnt == 4'd8;
    wire addr_match = shift[7:1] == dev_addr_byte[7:1];
    wire timed_out = seq_cnt >= seq_limit;
    always_ff @(posedge link_clk) begin
        rst_s <= {rst_s[0], reset};
        lrst <= rst_s[1];
        scl_s <= {scl_s[0], bus.scl};
        sda_s <= {sda_s[0], bus.sda};
        scl_q <= scl_hi;
        sda_q <= sda_hi;
    end
    // ****************************************************************
    // Protocol machine
    // ****************************************************************
    always_comb begin
        next_state = state;
        if (start_seen) begin
            next_state = st_addr;
        end else if (stop_seen || timed_out) begin
            next_state = st_idle;
        end else begin
            case (state)
                st_addr: if (byte_done) next_state = addr_match ? st_ack_out : st_ignore;
                st_rx: if (byte_done) next_state = st_ack_out;
                st_ack_out: if (scl_fall) next_state = rw ? st_tx : st_rx;
                st_tx: if (byte_done) next_state = st_ack_in;
                st_ack_in: if (scl_fall) next_state = got_nack ? st_ignore : st_tx;
                default: next_state = state;
            endcase
        end
    end
    always_ff @(posedge link_clk) begin
        if (lrst) begin
            state <= st_idle;
            shift <= 8'h00;
            bit_cnt <= 4'd0;
            rw <= 1'b0;
            drive_low <= 1'b0;
            got_nack <= 1'b0;
            seq_cnt <= 32'd0;
            rx_tgl <= 1'b0;
            tx_tgl <= 1'b0;
            busy_l <= 1'b0;
        end else begin
            state <= next_state;
            if (start_seen) busy_l <= 1'b1;
            else if (stop_seen) busy_l <= 1'b0;
            seq_cnt <= (state == st_idle || state == st_ignore) ? 32'd0 : seq_cnt + 32'd1;
            if (start_seen) begin
                bit_cnt <= 4'd0;
                drive_low <= 1'b0;
            end else if (scl_rise && bit_cnt < 4'd8) begin
                shift <= {shift[6:0], sda_hi};
                bit_cnt <= bit_cnt + 4'd1;
            end else if (scl_rise && state == st_ack_in) begin
                got_nack <= sda_hi;
            end else if (scl_fall) begin
                if (byte_done) begin
                    bit_cnt <= 4'd9;
                    if (state == st_addr) rw <= shift[0];
                    if (state == st_rx) rx_tgl <= ~rx_tgl;
                    // Ack a matching address and every received data byte: the receiver buffer is a single byte taken at once.
                    drive_low <= (state == st_addr && addr_match) || state == st_rx;
                end else if (next_state == st_tx) begin
                    shift <= (bit_cnt >= 4'd8) ? tx_data : shift;
                    if (bit_cnt >= 4'd8) begin
                        bit_cnt <= 4'd0;
                        tx_tgl <= ~tx_tgl;
                        drive_low <= !tx_data[7];
                    end else begin
                        drive_low <= !shift[7];
                    end
                end else begin
                    drive_low <= 1'b0;
                    if (bit_cnt >= 4'd8) bit_cnt <= 4'd0;
                end
            end
            if (next_state == st_idle || next_state == st_ignore) drive_low <= 1'b0;
        end
    end
    // Tx data bit is read at shift[7] before the rising-edge shift moves it away.
    assign bus.sda_d_out = 1'b0;
    assign bus.sda_d_oe_n = !drive_low;
    // ****************************************************************
    // Crossing to the core clock
    // ****************************************************************
    always_ff @(posedge core_clk) begin
        rx_tgl_s <= {rx_tgl_s[1:0], rx_tgl};
        tx_tgl_s <= {tx_tgl_s[1:0], tx_tgl};
        busy_s <= {busy_s[0], busy_l};
        if (reset) begin
            rx_valid <= 1'b0;
            tx_taken <= 1'b0;
            rx_data <= 8'h00;
            busy <= 1'b0;
        end else begin
            rx_valid <= rx_tgl_s[2] ^ rx_tgl_s[1];
            tx_taken <= tx_tgl_s[2] ^ tx_tgl_s[1];
            if (rx_tgl_s[2] ^ rx_tgl_s[1]) rx_data <= shift;
            busy <= busy_s[1];
        end
    end
endmodule // twi_device

// ===== rtl/twi_master.sv
// Host end: bus master that frames, clocks and acknowledges transfers.
`timescale 1ns/1ps
module twi_master (
    input wire logic core_clk,
    input wire logic reset,
    twi_if.master bus,
    input wire logic cmd_valid,
    input wire logic cmd_read,
    input wire logic [7:0] cmd_len,
    input wire logic [7:0] wr_data,
    output logic wr_taken,
    output logic [7:0] rd_data,
    output logic rd_valid,
    output logic done,
    output logic nacked
);
    import twi_pkg::*;
    // ****************************************************************
    // Bit engine
    // ****************************************************************
    typedef enum {m_idle, m_start, m_bit, m_stop} mstate_e;
    mstate_e state;
    logic [1:0] sda_s;
    logic [15:0] div;
    logic [1:0] phase;
    logic [3:0] bit_cnt;
    logic [8:0] shift;
    logic [7:0] left;
    logic rd, first, scl_low, sda_low, fail;
    wire tick = div == 16'(quarter_bit_cycles - 1);
    wire sda_in = sda_s[1];
    always_ff @(posedge core_clk) begin
        sda_s <= {sda_s[0], bus.sda};
        if (reset) begin
            state <= m_idle;
            div <= 16'd0;
            phase <= 2'd0;
            bit_cnt <= 4'd0;
            shift <= 9'h000;
            left <= 8'd0;
            rd <= 1'b0;
            first <= 1'b0;
            scl_low <= 1'b0;
            sda_low <= 1'b0;
            fail <= 1'b0;
            wr_taken <= 1'b0;
            rd_data <= 8'h00;
            rd_valid <= 1'b0;
            done <= 1'b0;
            nacked <= 1'b0;
        end else begin
            wr_taken <= 1'b0;
            rd_valid <= 1'b0;
            done <= 1'b0;
            div <= tick ? 16'd0 : div + 16'd1;
            case (state)
                m_idle: if (cmd_valid) begin
                    state <= m_start;
                    rd <= cmd_read;
                    left <= cmd_len;
                    shift <= {dev_addr_byte[7:1], cmd_read, 1'b1};
                    first <= 1'b1;
                    fail <= 1'b0;
                    div <= 16'd0;
                end
                m_start: if (tick) begin
                    sda_low <= 1'b1;
                    state <= m_bit;
                    phase <= 2'd0;
                    bit_cnt <= 4'd0;
                end
                m_bit: if (tick) begin
                    phase <= phase + 2'd1;
                    case (phase)
                        2'd0: begin
                            scl_low <= 1'b1;
                        end
                        2'd1: sda_low <= !shift[8];
                        2'd2: scl_low <= 1'b0;
                        default: begin
                            shift <= {shift[7:0], sda_in};
                            bit_cnt <= bit_cnt + 4'd1;
                            phase <= 2'd0;
                            if (bit_cnt == 4'd8) begin
                                bit_cnt <= 4'd0;
                                if (rd && !first) begin
                                    rd_data <= shift[7:0];
                                    rd_valid <= 1'b1;
                                end
                                if ((!rd || first) && sda_in) begin
                                    fail <= 1'b1;
                                    state <= m_stop;
                                end else if (left == 8'd0) begin
                                    state <= m_stop;
                                end else begin
                                    left <= left - 8'd1;
                                    first <= 1'b0;
                                    // Reads ack every byte but the last, which is nacked.
                                    shift <= rd ? {8'hff, left == 8'd1} : {wr_data, 1'b1};
                                    wr_taken <= !rd;
                                end
                            end
                        end
                    endcase
                end
                m_stop: if (tick) begin
                    phase <= phase + 2'd1;
                    case (phase)
                        2'd0: scl_low <= 1'b1;
                        2'd1: sda_low <= 1'b1;
                        2'd2: scl_low <= 1'b0;
                        default: begin
                            sda_low <= 1'b0;
                            state <= m_idle;
                            done <= 1'b1;
                            nacked <= fail;
                            phase <= 2'd0;
                        end
                    endcase
                end
                default: state <= m_idle;
            endcase
        end
    end
    assign bus.scl_out = 1'b0;
    assign bus.scl_oe_n = !scl_low;
    assign bus.sda_m_out = 1'b0;
    assign bus.sda_m_oe_n = !sda_low;
endmodule // twi_master

// ===== testbench/twi_props.sv
// Concurrent checks on the shared clock and data wires of the two-wire link.
`timescale 1ns/1ps
module twi_props (
    input wire logic core_clk,
    input wire logic reset,
    input wire logic scl,
    input wire logic sda,
    input wire logic sda_m_oe_n,
    input wire logic sda_d_out,
    input wire logic sda_d_oe_n
);
    import twi_pkg::*;
    // ****************************************************************
    // Bit position tracking
    // ****************************************************************
    logic [3:0] bit_cnt;
    logic first;
    logic dir;
    logic scl_d;
    logic nack_seen;
    logic sda_q;
    logic [6:0] addr_sh;
    logic [15:0] gap;
    wire scl_rise = scl && !scl_d;
    wire start_ev = scl && scl_d && sda_q && !sda;
    wire ack_slot = scl_rise && bit_cnt == 4'h8;
    wire rd_phase = !first && dir;
    wire addr_hit = addr_sh == dev_addr_byte[7:1];
    wire [15:0] next_gap = scl_rise ? 16'h0 : (gap == 16'hffff ? gap : gap + 16'h1);
    always_ff @(posedge core_clk) begin
        scl_d <= scl;
        sda_q <= sda;
        gap <= reset ? 16'hffff : next_gap;
        if (reset || start_ev) begin
            bit_cnt <= 4'h0;
            first <= 1'b1;
            nack_seen <= 1'b0;
        end else if (scl_rise) begin
            // After a nack the next rise belongs to the stop, where the master pulls data.
            nack_seen <= nack_seen || (bit_cnt == 4'h8 && sda);
            bit_cnt <= (bit_cnt == 4'h8) ? 4'h0 : bit_cnt + 4'h1;
            first <= first && bit_cnt != 4'h8;
            addr_sh <= (first && bit_cnt < 4'h7) ? {addr_sh[5:0], sda} : addr_sh;
            dir <= (first && bit_cnt == 4'h7) ? sda : dir;
        end
    end
    // ****************************************************************
    // Assertions
    // ****************************************************************
    default clocking cb @(posedge core_clk); endclocking
    default disable iff (reset);
    sequence stop_seq;
        scl && $past(scl) && $rose(sda);
    endsequence
    sequence ack_low;
        (!sda) [*8];
    endsequence
    dev_pull_only_a: assert property (!sda_d_oe_n |-> !sda_d_out)
        else $error("device drove data high");
    dev_hold_high_a: assert property (scl && $past(scl) |-> $stable(sda_d_oe_n))
        else $error("device changed data while clock high");
    addr_ack_a: assert property (ack_slot && first && addr_hit |-> ack_low)
        else $error("matching address not acknowledged");
    wr_ack_a: assert property (ack_slot && !first && !dir |-> ack_low)
        else $error("written byte not acknowledged low");
    tx_release_a: assert property (ack_slot && !rd_phase |-> sda_m_oe_n)
        else $error("master held data in acknowledge slot");
    rd_release_a: assert property (ack_slot && rd_phase |-> sda_d_oe_n)
        else $error("device held data in read acknowledge slot");
    dev_quiet_wr_a: assert property (scl_rise && bit_cnt != 4'h8 && !rd_phase |-> sda_d_oe_n)
        else $error("device drove a bit it receives");
    mst_quiet_rd_a: assert property (scl_rise && bit_cnt != 4'h8 && rd_phase && !nack_seen |-> sda_m_oe_n)
        else $error("master drove a bit it receives");
    nack_stop_a: assert property (ack_slot && rd_phase && sda |=> sda_d_oe_n [*8])
        else $error("device kept sending after nack");
    bit_rate_a: assert property (scl_rise && gap != 16'hffff |-> gap >= 16'd2499)
        else $error("clock period below the bit rate limit");
    stop_idle_a: assert property (stop_seq |=> sda_d_oe_n [*8])
        else $error("device drove data after stop");
endmodule // twi_props

// ===== testbench/tb_top.sv
// Self-checking bench joining the bus master to the sensor port.
`timescale 1ns/1ps
module tb_top;
    import twi_pkg::*;
    logic core_clk = 1'b0;
    logic link_clk = 1'b0;
    logic reset = 1'b1;
    logic cmd_valid = 1'b0;
    logic cmd_read = 1'b0;
    logic [7:0] cmd_len = 8'h01;
    logic [7:0] wr_data = 8'h00;
    logic [7:0] tx_data = 8'h00;
    logic [7:0] rd_data;
    logic [7:0] rx_data;
    logic [7:0] seed;
    logic wr_taken, rd_valid, done, nacked, tx_taken, rx_valid, busy;
    int failures = 0;
    int compares = 0;
    int cycles = 0;
    int n_taken = 0;
    int n_wr = 0;
    logic [7:0] exp_rx[$];
    logic [7:0] exp_rd[$];
    twi_if bus_if ();
    twi_master i_twi_master (.core_clk(core_clk), .reset(reset), .bus(bus_if),
        .cmd_valid(cmd_valid), .cmd_read(cmd_read), .cmd_len(cmd_len), .wr_data(wr_data),
        .wr_taken(wr_taken), .rd_data(rd_data), .rd_valid(rd_valid), .done(done),
        .nacked(nacked));
    // A shortened limit keeps the abandon counter reachable yet longer than one frame.
    twi_device #(.seq_limit(20000)) i_twi_device (.link_clk(link_clk), .core_clk(core_clk),
        .reset(reset), .bus(bus_if), .tx_data(tx_data), .tx_taken(tx_taken),
        .rx_data(rx_data), .rx_valid(rx_valid), .busy(busy));
    twi_props i_twi_props (.core_clk(core_clk), .reset(reset), .scl(bus_if.scl),
        .sda(bus_if.sda), .sda_m_oe_n(bus_if.sda_m_oe_n), .sda_d_out(bus_if.sda_d_out),
        .sda_d_oe_n(bus_if.sda_d_oe_n));
    always #2 core_clk = ~core_clk;
    initial begin
        #7;
        forever #32 link_clk = ~link_clk;
    end
    function automatic logic [7:0] lfsr(input logic [7:0] v);
        return {v[6:0], v[7] ^ v[5] ^ v[4] ^ v[3]};
    endfunction
    task automatic check(input string what, input logic [7:0] seen, input logic [7:0] exp);
        compares++;
        if (seen !== exp) begin
            failures++;
            $display("Error %s expected %h seen %h", what, exp, seen);
        end
    endtask
    task automatic conclude();
        $display("Compares %0d failures %0d", compares, failures);
        if (failures == 0 && compares > 0) begin
            $display("All checks passed");
        end else begin
            $display("Checks failed");
        end
        $finish;
    endtask
    // Waits on done are bounded by the cycle ceiling in the monitor below.
    task automatic transfer(input logic rd);
        @(posedge core_clk);
        #1 cmd_read = rd;
        cmd_valid = 1'b1;
        @(posedge core_clk);
        #1 cmd_valid = 1'b0;
        do @(negedge core_clk); while (done !== 1'b1);
        check("nacked", {7'h0, nacked}, 8'h00);
        repeat (16) @(posedge link_clk);
        #1 check("busy after stop", {7'h0, busy}, 8'h00);
    endtask
    always @(negedge core_clk) begin
        if (rx_valid === 1'b1) begin
            check("rx_data", rx_data, exp_rx.pop_front());
            check("busy in frame", {7'h0, busy}, 8'h01);
        end
        if (rd_valid === 1'b1) begin
            check("rd_data", rd_data, exp_rd.pop_front());
        end
        if (tx_taken === 1'b1) begin
            n_taken++;
        end
        if (wr_taken === 1'b1) begin
            n_wr++;
        end
        cycles++;
        if (cycles == 150000) begin
            failures++;
            conclude();
        end
    end
    // ****************************************************************
    // Main sequence
    // ****************************************************************
    initial begin
        seed = 8'h0a;
        // Reset spans link edges too, since the port logic runs on the slower clock.
        repeat (8) @(posedge link_clk);
        @(posedge core_clk);
        #1 reset = 1'b0;
        seed = lfsr(seed);
        wr_data = seed;
        exp_rx.push_back(seed);
        transfer(1'b0);
        seed = lfsr(seed);
        tx_data = seed;
        exp_rd.push_back(seed);
        transfer(1'b1);
        check("bytes loaded", n_taken[7:0], 8'h01);
        check("bytes written", n_wr[7:0], 8'h01);
        check("bytes left", 8'(exp_rx.size() + exp_rd.size()), 8'h00);
        conclude();
    end
endmodule // tb_top
